// ---- design/iap_regs.vh ----
// register map, field positions, reset values and codes of the self-programming block
`ifndef IAP_REGS_VH
`define IAP_REGS_VH
`define IAP_ADDR_SYSCTL 8'hBF
`define IAP_ADDR_FAHI 8'hF4
`define IAP_ADDR_FALO 8'hF5
`define IAP_ADDR_FDATA 8'hF6
`define IAP_ADDR_FCTRL 8'hF7
`define IAP_SC_WDR 7
`define IAP_SC_DZE 3
`define IAP_SC_SPE 2
`define IAP_SC_XRE 1
`define IAP_SC_LSI 0
`define IAP_SC_RESET 8'h02
`define IAP_SC_WMASK 8'h0F
`define IAP_FC_LAUNCH 7
`define IAP_FC_ZONE 5
`define IAP_FC_WMASK 8'h23
`define IAP_FN_BYTE 2'h0
`define IAP_FN_PROT 2'h1
`define IAP_FN_PAGE 2'h2
`define IAP_FN_CHIP 2'h3
`define IAP_KEY_A 8'h55
`define IAP_KEY_B 8'hAA
`define IAP_ZERO8 8'h00
`define IAP_ST_IDLE 2'h0
`define IAP_ST_ISSUE 2'h1
`define IAP_ST_WAIT 2'h2
`define IAP_ST_DONE 2'h3
`define IAP_UL_IDLE 2'h0
`define IAP_UL_ONE 2'h1
`define IAP_UL_TWO 2'h2
`define IAP_UL_OPEN 2'h3
`endif

// ---- design/iap_self_prog.v ----
// self-programming controller: special-function registers, unlock and flash sequencing
//
// Overview of operation
// [R1] watchdog reset sets flag bit 7
// [R2] data zone off by default, bit 3 enables
// [R3] operations only while enable bit 2 set
// [R4] bit 1 enables extra 768-byte RAM
// [R5] bit 0 inhibits divided clock on latch pin
// [R6] target address from high F4, low F5
// [R7] operation byte from data register F6
// [R8] control bit 5 selects zone, address bit 16
// [R9] writing launch bit 7 starts function bits 1:0
// [R10] no operation while launch bit reads 0
// [R11] codes: program, protect, page, chip erase
// [R12] chip erase spares locked boot region
// [R13] launch bit read-only until unlocked
// [R14] unlock by writing 55, AA, 55 to data
// [R15] sample registers, stall counter during operation
// [R16] completion clears launch, releases counter
// [R17] page erase: 512 bytes, even/odd pair, boot spared
// [R18] software zeroes low address for page erase
// [R19] chip erase also removes read protection
// [R20] protected flash reads back as zero
// [R21] wrong data byte restarts unlock sequence
// [R22] launch without enable clears at once
`timescale 1ns/10ps
`include "iap_regs.vh"
module iap_self_prog #(
  parameter BOOT_BASE_HI = 8'hF2
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_wdt_reset,
  input wire i_boot_lock,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_wdata,
  input wire [7:0] i_flash_rdata,
  input wire i_flash_done,
  input wire i_div6_clk,
  output reg [7:0] o_sfr_rdata,
  output reg o_pc_hold,
  output reg o_data_zone_enable,
  output reg o_extra_ram_enable,
  output reg o_latch_strobe,
  output reg o_flash_req,
  output reg [1:0] o_flash_op,
  output reg [16:0] o_flash_addr,
  output reg [7:0] o_flash_wdata,
  output reg o_flash_keep_boot,
  output reg [7:0] o_flash_read
);
  ////////////////////////////////////////////////////////////////////
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction
  reg [7:0] system_control;
  reg [7:0] flash_addr_high;
  reg [7:0] flash_addr_low;
  reg [7:0] flash_data;
  reg zone_select;
  reg [1:0] op_function;
  reg op_launch;
  reg read_protect;
  reg [1:0] state;
  reg wdt_s1;
  reg wdt_s2;
  reg done_s1;
  reg done_s2;
  reg div_s1;
  reg div_s2;
  wire unlock_open;
  wire wr_sc = i_sfr_wr && hit(i_sfr_addr, `IAP_ADDR_SYSCTL);
  wire wr_fc = i_sfr_wr && hit(i_sfr_addr, `IAP_ADDR_FCTRL);
  wire wr_fd = i_sfr_wr && hit(i_sfr_addr, `IAP_ADDR_FDATA);
  wire launch_wr = wr_fc && i_sfr_wdata[`IAP_FC_LAUNCH] && unlock_open; // [R13]
  wire consume = launch_wr;
  ////////////////////////////////////////////////////////////////////
  iap_unlock u_unlock (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_data_wr(wr_fd && state == `IAP_ST_IDLE),
    .i_data(i_sfr_wdata),
    .i_consume(consume),
    .o_open(unlock_open)
  );
  // pins from outside the clock domain pass two flops
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      div_s1 <= 1'b0;
      div_s2 <= 1'b0;
    end else begin
      done_s1 <= i_flash_done;
      done_s2 <= done_s1;
      div_s1 <= i_div6_clk;
      div_s2 <= div_s1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // watchdog flag survives the reset it marks: caught from the held cause
  // no reset on this pair, so the cause is still seen while reset is held
  always @(posedge i_mclk) begin
    wdt_s1 <= i_wdt_reset;
    wdt_s2 <= wdt_s1;
  end
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      system_control <= `IAP_SC_RESET;
      system_control[`IAP_SC_WDR] <= wdt_s2; // [R1]
    end else begin
      if (wr_sc) begin
        system_control[3:0] <= i_sfr_wdata[3:0];
      end
      if (wdt_s2) begin
        system_control[`IAP_SC_WDR] <= 1'b1; // [R1]
      end else if (wr_sc) begin
        system_control[`IAP_SC_WDR] <= i_sfr_wdata[`IAP_SC_WDR];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // operand registers frozen while an operation runs, software is stalled anyway
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      flash_addr_high <= `IAP_ZERO8;
      flash_addr_low <= `IAP_ZERO8;
      flash_data <= `IAP_ZERO8;
      zone_select <= 1'b0;
      op_function <= `IAP_FN_BYTE;
    end else if (state == `IAP_ST_IDLE && i_sfr_wr) begin
      if (hit(i_sfr_addr, `IAP_ADDR_FAHI)) begin
        flash_addr_high <= i_sfr_wdata; // [R6]
      end
      if (hit(i_sfr_addr, `IAP_ADDR_FALO)) begin
        flash_addr_low <= i_sfr_wdata; // [R6]
      end
      if (wr_fd) begin
        flash_data <= i_sfr_wdata; // [R7]
      end
      if (wr_fc) begin
        zone_select <= i_sfr_wdata[`IAP_FC_ZONE]; // [R8]
        op_function <= i_sfr_wdata[1:0]; // [R11]
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // sequencer; launch bit is the only thing that starts anything
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= `IAP_ST_IDLE;
      op_launch <= 1'b0;
      o_pc_hold <= 1'b0;
      o_flash_req <= 1'b0;
      o_flash_op <= `IAP_FN_BYTE;
      o_flash_addr <= 17'h00000;
      o_flash_wdata <= `IAP_ZERO8;
      o_flash_keep_boot <= 1'b0;
      read_protect <= 1'b0;
    end else begin
      o_flash_req <= 1'b0;
      case (state)
        `IAP_ST_IDLE: begin
          if (launch_wr && state == `IAP_ST_IDLE) begin // [R9] [R10]
            op_launch <= 1'b1;
            if (system_control[`IAP_SC_SPE]) begin // [R3]
              state <= `IAP_ST_ISSUE;
              o_pc_hold <= 1'b1; // [R15]
            end else begin
              state <= `IAP_ST_DONE; // [R22]
            end
          end
        end
        `IAP_ST_ISSUE: begin
          o_flash_op <= op_function; // [R11]
          o_flash_addr <= {zone_select, flash_addr_high, flash_addr_low}; // [R8] [R15]
          if (op_function == `IAP_FN_PAGE) begin
            o_flash_addr <= {zone_select, flash_addr_high[7:1], 9'h000}; // [R17]
          end
          o_flash_wdata <= flash_data; // [R7]
          o_flash_keep_boot <= i_boot_lock; // [R12]
          // a page inside the boot area is refused outright
          if (op_function == `IAP_FN_PAGE && !zone_select &&
              flash_addr_high >= BOOT_BASE_HI) begin
            state <= `IAP_ST_DONE; // [R17]
          end else if (op_function == `IAP_FN_BYTE && zone_select &&
                       !system_control[`IAP_SC_DZE]) begin
            state <= `IAP_ST_DONE; // [R2]
          end else begin
            o_flash_req <= 1'b1;
            state <= `IAP_ST_WAIT;
          end
        end
        `IAP_ST_WAIT: begin
          if (done_s2) begin
            if (o_flash_op == `IAP_FN_PROT) begin
              read_protect <= 1'b1;
            end else if (o_flash_op == `IAP_FN_CHIP) begin
              read_protect <= 1'b0; // [R19]
            end
            state <= `IAP_ST_DONE;
          end
        end
        `IAP_ST_DONE: begin
          op_launch <= 1'b0; // [R16] [R22]
          o_pc_hold <= 1'b0; // [R16]
          state <= `IAP_ST_IDLE;
        end
        default: state <= `IAP_ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= `IAP_ZERO8;
      o_data_zone_enable <= 1'b0;
      o_extra_ram_enable <= 1'b0;
      o_latch_strobe <= 1'b0;
      o_flash_read <= `IAP_ZERO8;
    end else begin
      o_data_zone_enable <= system_control[`IAP_SC_DZE]; // [R2]
      o_extra_ram_enable <= system_control[`IAP_SC_XRE]; // [R4]
      o_latch_strobe <= div_s2 & ~system_control[`IAP_SC_LSI]; // [R5]
      o_flash_read <= read_protect ? `IAP_ZERO8 : i_flash_rdata; // [R20]
      o_sfr_rdata <= `IAP_ZERO8;
      if (i_sfr_rd) begin
        case (i_sfr_addr)
          `IAP_ADDR_SYSCTL: o_sfr_rdata <= {system_control[7], 3'h0, system_control[3:0]};
          `IAP_ADDR_FAHI: o_sfr_rdata <= flash_addr_high;
          `IAP_ADDR_FALO: o_sfr_rdata <= flash_addr_low;
          `IAP_ADDR_FDATA: o_sfr_rdata <= flash_data;
          `IAP_ADDR_FCTRL: o_sfr_rdata <= {op_launch, 1'b0, zone_select, 3'h0, op_function};
          default: o_sfr_rdata <= `IAP_ZERO8;
        endcase
      end
    end
  end
endmodule

// ---- design/iap_unlock.v ----
// three-write unlock detector guarding the launch bit
`timescale 1ns/10ps
`include "iap_regs.vh"
module iap_unlock (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_data_wr,
  input wire [7:0] i_data,
  input wire i_consume,
  output wire o_open
);
  reg [1:0] step;
  reg [1:0] next_step;
  assign o_open = (step == `IAP_UL_OPEN);
  always @* begin
    next_step = step;
    if (i_consume) begin
      next_step = `IAP_UL_IDLE;
    end else if (i_data_wr && step != `IAP_UL_OPEN) begin
      case (step)
        `IAP_UL_IDLE: next_step = (i_data == `IAP_KEY_A) ? `IAP_UL_ONE : `IAP_UL_IDLE; // [R14]
        `IAP_UL_ONE: next_step = (i_data == `IAP_KEY_B) ? `IAP_UL_TWO :
          ((i_data == `IAP_KEY_A) ? `IAP_UL_ONE : `IAP_UL_IDLE); // [R21]
        `IAP_UL_TWO: next_step = (i_data == `IAP_KEY_A) ? `IAP_UL_OPEN : `IAP_UL_IDLE; // [R21]
        default: next_step = `IAP_UL_IDLE;
      endcase
    end
  end
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      step <= `IAP_UL_IDLE;
    end else begin
      step <= next_step;
    end
  end
endmodule

// ---- verification/iap_checker.sv ----
// port assertions for the self-programming block
`timescale 1ns/10ps
module iap_checker (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_wdata,
  input wire i_flash_done,
  input wire [7:0] o_sfr_rdata,
  input wire o_pc_hold,
  input wire o_data_zone_enable,
  input wire o_extra_ram_enable,
  input wire o_latch_strobe,
  input wire o_flash_req,
  input wire [1:0] o_flash_op,
  input wire [16:0] o_flash_addr,
  input wire [7:0] o_flash_wdata
);
  // shadow of writable fields; writes while stalled are dropped
  reg [7:0] ah, al, fd;
  reg zn, spe, dz, xr, lsi;
  reg [1:0] age;
  wire w = i_sfr_wr && !o_pc_hold;
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      {ah, al, fd, zn} <= 25'h0;
      {dz, spe, xr, lsi} <= 4'h2;
      age <= 2'h0;
    end else begin
      if (age != 2'h3) age <= age + 2'h1;
      if (w && i_sfr_addr == 8'hBF) {dz, spe, xr, lsi} <= i_sfr_wdata[3:0];
      if (w && i_sfr_addr == 8'hF4) ah <= i_sfr_wdata;
      if (w && i_sfr_addr == 8'hF5) al <= i_sfr_wdata;
      if (w && i_sfr_addr == 8'hF6) fd <= i_sfr_wdata;
      if (w && i_sfr_addr == 8'hF7) zn <= i_sfr_wdata[5];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  chk_req_stall: assert property (o_flash_req |-> o_pc_hold)
    else $error("flash request without core stall");
  chk_req_pulse: assert property (o_flash_req |=> !o_flash_req)
    else $error("flash request longer than one cycle");
  chk_addr_pair: assert property (o_flash_req |-> o_flash_addr ==
    (o_flash_op == 2'h2 ? {zn, ah[7:1], 9'h0} : {zn, ah, al}))
    else $error("flash address not formed from registers");
  chk_data_byte: assert property (o_flash_req |-> o_flash_wdata == fd)
    else $error("flash data not taken from data register");
  chk_enable_gate: assert property (o_flash_req |-> spe)
    else $error("flash request while disabled");
  chk_latch_quiet: assert property (lsi && $past(lsi, 3) |-> !o_latch_strobe)
    else $error("latch pin active while inhibited");
  chk_zone_ram: assert property (age == 2'h3 && dz == $past(dz, 2) && xr == $past(xr, 2)
    |-> o_data_zone_enable == dz && o_extra_ram_enable == xr)
    else $error("enable outputs differ from control bits");
  chk_done_release: assert property ($rose(i_flash_done) && o_pc_hold
    |-> ##[1:8] !o_pc_hold)
    else $error("stall not released after completion");
  chk_read_idle: assert property (!$past(i_sfr_rd) |-> o_sfr_rdata == 8'h00)
    else $error("read data present without read");
  cov_page: cover property (o_flash_req && o_flash_op == 2'h2);
  cov_data_zone: cover property (o_flash_req && o_flash_addr[16]);
  cov_release: cover property ($fell(o_pc_hold));
endmodule
bind iap_self_prog iap_checker i_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wdata(i_sfr_wdata), .i_flash_done(i_flash_done), .o_sfr_rdata(o_sfr_rdata),
  .o_pc_hold(o_pc_hold), .o_data_zone_enable(o_data_zone_enable),
  .o_extra_ram_enable(o_extra_ram_enable), .o_latch_strobe(o_latch_strobe),
  .o_flash_req(o_flash_req), .o_flash_op(o_flash_op), .o_flash_addr(o_flash_addr),
  .o_flash_wdata(o_flash_wdata));

// ---- verification/iap_flash_model.sv ----
// flash array stand-in: one done pulse per request after a fixed delay
`timescale 1ns/10ps
module iap_flash_model #(
  parameter LAT = 5
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_req,
  output reg o_done
);
  integer cnt;
  always @(posedge i_mclk) begin
    if (!i_rst_n || i_req) cnt <= i_rst_n ? LAT : 0;
    else if (cnt != 0) cnt <= cnt - 1;
    o_done <= i_rst_n && cnt == 1;
  end
endmodule

// ---- verification/iap_self_prog_test.sv ----
// self-checking bench for the self-programming block
`timescale 1ns/10ps
module iap_self_prog_test;
  reg i_mclk = 1'b0;
  reg i_rst_n = 1'b0;
  reg i_wdt_reset = 1'b1;
  reg i_boot_lock = 1'b1;
  reg i_sfr_wr = 1'b0;
  reg i_sfr_rd = 1'b0;
  reg [7:0] i_sfr_addr = 8'h00;
  reg [7:0] i_sfr_wdata = 8'h00;
  reg [7:0] i_flash_rdata = 8'hA5;
  reg i_div6_clk = 1'b0;
  wire [7:0] o_sfr_rdata, o_flash_wdata, o_flash_read;
  wire o_pc_hold, o_data_zone_enable, o_extra_ram_enable, o_latch_strobe;
  wire o_flash_req, o_flash_keep_boot, i_flash_done;
  wire [1:0] o_flash_op;
  wire [16:0] o_flash_addr;
  integer fail_count = 0;
  integer tests_run = 0;
  integer reqs = 0;
  integer n, f;
  reg [1:0] op;
  reg [16:0] adr;
  reg [7:0] wd;
  reg kb;
  always #5 i_mclk = ~i_mclk;
  always #30 i_div6_clk = ~i_div6_clk;
  iap_self_prog i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wdt_reset(i_wdt_reset),
    .i_boot_lock(i_boot_lock), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_flash_rdata(i_flash_rdata), .i_flash_done(i_flash_done),
    .i_div6_clk(i_div6_clk), .o_sfr_rdata(o_sfr_rdata), .o_pc_hold(o_pc_hold),
    .o_data_zone_enable(o_data_zone_enable), .o_extra_ram_enable(o_extra_ram_enable),
    .o_latch_strobe(o_latch_strobe), .o_flash_req(o_flash_req), .o_flash_op(o_flash_op),
    .o_flash_addr(o_flash_addr), .o_flash_wdata(o_flash_wdata),
    .o_flash_keep_boot(o_flash_keep_boot), .o_flash_read(o_flash_read));
  iap_flash_model #(.LAT(5)) i_flash (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_req(o_flash_req), .o_done(i_flash_done));
  always @(posedge i_mclk) if (o_flash_req === 1'b1) begin
    reqs <= reqs + 1;
    op <= o_flash_op;
    adr <= o_flash_addr;
    wd <= o_flash_wdata;
    kb <= o_flash_keep_boot;
  end
  ////////////////////////////////////////
  task chk(input [16:0] g, input [16:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge i_mclk);
    {i_sfr_wr, i_sfr_addr, i_sfr_wdata} = {1'b1, a, d};
    @(negedge i_mclk);
    i_sfr_wr = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(negedge i_mclk);
    {i_sfr_rd, i_sfr_addr} = {1'b1, a};
    @(negedge i_mclk);
    i_sfr_rd = 1'b0;
    chk(o_sfr_rdata, e);
  endtask
  task unlock;
    wr(8'hF6, 8'h55);
    wr(8'hF6, 8'hAA);
    wr(8'hF6, 8'h55);
  endtask
  // launches refused for lack of enable finish in two cycles without a stall, so a short floor is enough
  task go(input [7:0] c, input integer k);
    integer r0;
    r0 = reqs;
    wr(8'hF7, c);
    n = 0;
    while ((o_pc_hold !== 1'b0 || n < 4) && n < 60) begin
      @(negedge i_mclk);
      n = n + 1;
    end
    chk(n == 60, 0);
    chk(reqs - r0, k);
    rd(8'hF7, c & 8'h23);
  endtask
  ////////////////////////////////////////
  task t_reset;
    rd(8'hBF, 8'h82);
    chk(o_data_zone_enable, 0);
    chk(o_extra_ram_enable, 1);
    rd(8'hF7, 8'h00);
    $display("t_reset done");
  endtask
  task t_locked;
    wr(8'hBF, 8'h04);
    go(8'h80, 0);
    wr(8'hF6, 8'h55);
    wr(8'hF6, 8'h12);
    wr(8'hF6, 8'hAA);
    wr(8'hF6, 8'h55);
    go(8'h80, 0);
    $display("t_locked done");
  endtask
  task t_byte;
    wr(8'hBF, 8'h0C);
    unlock;
    wr(8'hF4, 8'h12);
    wr(8'hF5, 8'h34);
    wr(8'hF6, 8'h5A);
    go(8'hA0, 1);
    chk(adr, 17'h11234);
    chk(wd, 8'h5A);
    $display("t_byte done");
  endtask
  task t_page;
    wr(8'hBF, 8'h04);
    unlock;
    wr(8'hF4, 8'hB1);
    wr(8'hF5, 8'h00);
    go(8'h82, 1);
    chk(adr, 17'h0B000);
    unlock;
    wr(8'hF4, 8'hF2);
    go(8'h82, 0);
    $display("t_page done");
  endtask
  task t_funcs;
    wr(8'hBF, 8'h0C);
    wr(8'hF4, 8'hB1);
    for (f = 0; f < 4; f = f + 1) begin
      unlock;
      go(8'hA0 | f, 1);
      chk(op, f);
      chk(o_flash_read, (f == 1 || f == 2) ? 8'h00 : 8'hA5);
    end
    chk(kb, 1);
    i_boot_lock = 1'b0;
    unlock;
    go(8'hA3, 1);
    chk(kb, 0);
    $display("t_funcs done");
  endtask
  task t_noen;
    wr(8'hBF, 8'h08);
    unlock;
    go(8'h80, 0);
    $display("t_noen done");
  endtask
  task t_latch;
    wr(8'hBF, 8'h01);
    repeat (3) @(negedge i_mclk);
    for (n = 0; n < 12; n = n + 1) begin
      @(negedge i_mclk);
      chk(o_latch_strobe, 0);
    end
    wr(8'hBF, 8'h00);
    f = 0;
    for (n = 0; n < 16; n = n + 1) begin
      @(negedge i_mclk);
      f = f | o_latch_strobe;
    end
    chk(f, 1);
    $display("t_latch done");
  endtask
  task final_report;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1'b1;
    i_wdt_reset = 1'b0;
    t_reset;
    t_locked;
    t_byte;
    t_page;
    t_funcs;
    t_noen;
    t_latch;
    final_report;
  end
  initial begin
    #100000;
    fail_count = fail_count + 1;
    final_report;
  end
endmodule
